// File: tb.sv
// Self-checking bench of the capture path
`timescale 1ns/1ps
`default_nettype none
module tb;
    import vpc_pkg::*;
    typedef struct {logic [15:0] a; logic [31:0] d; logic [31:0] e;} vpc_row_s;
    typedef struct {logic [31:0] bm; logic [31:0] lm; logic [8:0] h; int n;} vpc_cap_s;
    logic        ref_clk = 1'b0, port_pixel_clock = 1'b0, resetn = 1'b0;
    logic [15:0] reg_addr = 16'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, fifo_data;
    logic        reg_wr = 1'b0, reg_rd = 1'b0, fifo_push, line_sync, frame_sync;
    logic [3:0]  fifo_free = 4'h9;
    logic [2:0]  transaction_type;
    logic [7:0]  pix_data;
    vpc_fbwr_s   fb_wr;
    int          errors = 0, compares = 0, nwr = 0;
    logic [21:0] first = 22'h0;
    vpc_row_s rows[7] = '{'{OFS_WSIZE, 32'hffffffff, 32'h01ff0fff}, '{OFS_OFFS, 32'hffffffff, 32'h01ff0fff},
        '{OFS_BMASK, 32'ha5a5a5a5, 32'ha5a5a5a5}, '{OFS_LMASK, 32'h5a5a5a5a, 32'h5a5a5a5a},
        '{OFS_STRIDE, 32'hffffffff, 32'h00000fff}, '{OFS_BASE, 32'hffffffff, 32'h003fffff},
        '{16'h0000, 32'hffffffff, 32'h00000000}};
    vpc_cap_s caps[4] = '{'{32'h0, 32'hffffffff, 9'h0, 4}, '{32'h4, 32'hffffffff, 9'h0, 3},
        '{32'h0, 32'hfffffff1, 9'h0, 0}, '{32'h0, 32'hffffffff, 9'h1, 8}};
    initial forever #2.5 ref_clk = ~ref_clk;
    initial begin
        #1.3;
        forever #6 port_pixel_clock = ~port_pixel_clock;
    end
    vpc_capture i_vpc_capture (.ref_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .fifo_free, .fifo_push, .fifo_data, .transaction_type, .port_pixel_clock, .line_sync,
        .frame_sync, .pix_data, .fb_wr);
    vpc_digitizer i_vpc_digitizer (.port_pixel_clock, .line_sync, .frame_sync, .pix_data);
    always @(posedge port_pixel_clock) begin
        if (fb_wr.we === 1'b1) begin
            if (nwr == 0) first = fb_wr.addr;
            nwr++;
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] e, input string n);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(n, e, reg_rdata);
    endtask
    task automatic grab(input logic [31:0] c);
        wr(OFS_CTRL, c);
        repeat (60) @(posedge ref_clk);
        nwr = 0;
        i_vpc_digitizer.frame(4);
        repeat (8) @(posedge ref_clk);
    endtask
    task automatic finish_test();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge ref_clk);
        chk("rdata in reset", 32'h0, reg_rdata);
        resetn <= 1'b1;
        rd(OFS_LMASK, 32'h0, "lmask reset");
        rd(OFS_STRIDE, 32'h0, "stride reset");
        $display("test reset done");
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e, "readback");
        end
        $display("test registers done");
        wr(OFS_OFFS, 32'h00010000);
        wr(OFS_STRIDE, 32'h00000010);
        wr(OFS_BASE, 32'h00000100);
        foreach (caps[i]) begin
            wr(OFS_BMASK, caps[i].bm);
            wr(OFS_LMASK, caps[i].lm);
            wr(OFS_WSIZE, {7'h0, caps[i].h, 16'h0002});
            grab(32'h1);
            chk("writes", caps[i].n, nwr);
            if (caps[i].n > 0) chk("line start", 32'h110, {10'h0, first});
        end
        $display("test capture done");
        grab(32'h3);
        chk("pass writes", 32'h1, {31'h0, nwr > 8});
        $display("test pass done");
        wr(OFS_FIFO, 32'hcafe0001);
        chk("push", 32'h1, {31'h0, fifo_push});
        chk("type", 32'h6, {29'h0, transaction_type});
        wr(16'hff5c, 32'h0000beef);
        chk("last word", 32'h0000beef, fifo_data);
        wr(16'hff42, 32'h12345678);
        chk("skewed", 32'h0000beef, fifo_data);
        rd(OFS_STAT, 32'h00000069, "status");
        $display("test fifo done");
        finish_test();
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        finish_test();
    end
endmodule
bind vpc_capture vpc_props i_vpc_props (.ref_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .fifo_free, .fifo_push, .fifo_data, .transaction_type, .port_pixel_clock, .line_sync,
    .frame_sync, .pix_data, .fb_wr);
`default_nettype wire

// File: vpc_capture.sv
// Video port capture path: register file, config crossing and link capture
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module vpc_capture
    import vpc_pkg::*;
(
    input  wire logic        ref_clk,          // System clock, 200 MHz
    input  wire logic        resetn,           // Async reset, active low
    input  wire logic [15:0] reg_addr,         // Register byte address
    input  wire logic [31:0] reg_wdata,        // Write data
    input  wire logic        reg_wr,           // Write strobe
    input  wire logic        reg_rd,           // Read strobe
    output logic      [31:0] reg_rdata,        // Read data, cycle after strobe
    input  wire logic [3:0]  fifo_free,        // Free words in data FIFO
    output logic             fifo_push,        // Push pulse to data FIFO
    output logic      [31:0] fifo_data,        // Word pushed
    output logic      [2:0]  transaction_type, // Current transaction type
    input  wire logic        port_pixel_clock, // Link pixel clock
    input  wire logic        line_sync,        // Line sync pin, high active
    input  wire logic        frame_sync,       // Frame sync pin, high active
    input  wire logic [7:0]  pix_data,         // Pixel byte pin bus
    output vpc_fbwr_s        fb_wr             // Frame buffer byte write
);

    ////////////////////////////////////////////////////////////////////
    typedef struct packed {
        vpc_cfg_s    cfg;
        vpc_cfg_s    shadow;
        logic        dirty;
        logic        req;
        logic        ack_s1;
        logic        ack_s2;
        logic [2:0]  tt;
        logic [31:0] rdata;
        logic        push;
        logic [31:0] pdata;
    } vpc_ref_s;

    typedef struct packed {
        logic        req_s1;
        logic        req_s2;
        logic        req_seen;
        vpc_cfg_s    cfg;
        logic [2:0]  hs;
        logic [2:0]  vs;
        logic [7:0]  pd_s1;
        logic [7:0]  pd_s2;
        logic [12:0] hcnt;
        logic [8:0]  vline;
        logic [9:0]  lines;
        logic [4:0]  vdec;
        logic [6:0]  bcnt;
        logic [12:0] pcnt;
        logic        first;
        logic        line_on;
        logic [21:0] line_start;
        logic [21:0] addr;
        vpc_fbwr_s   out;
    } vpc_link_s;

    vpc_ref_s  r;
    vpc_ref_s  next_r;
    vpc_link_s l;
    vpc_link_s next_l;

    function automatic logic is_video(input vpc_mode_e m);
        is_video = (m == MODE_VIDEO8) || (m == MODE_VIDEO16);
    endfunction

    function automatic logic [12:0] sat13(input logic [12:0] v);
        sat13 = (v == 13'h1fff) ? v : v + 13'h0001;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Register side
    always_comb begin
        next_r = r;
        next_r.push = 1'b0;
        next_r.ack_s1 = l.req_seen;
        next_r.ack_s2 = r.ack_s1;
        next_r.rdata = REG_RESET;
        if (reg_wr) begin
            next_r.dirty = 1'b1;
            unique case (reg_addr)
                OFS_WSIZE: begin
                    next_r.cfg.width = reg_wdata[LO_LSB +: 12];
                    next_r.cfg.height = reg_wdata[HI_LSB +: 9];
                end
                OFS_OFFS: begin
                    next_r.cfg.hoff = reg_wdata[LO_LSB +: 12];
                    next_r.cfg.voff = reg_wdata[HI_LSB +: 9];
                end
                OFS_BMASK:  next_r.cfg.bmask = reg_wdata;
                OFS_LMASK:  next_r.cfg.lmask = reg_wdata;
                OFS_STRIDE: next_r.cfg.stride = reg_wdata[LO_LSB +: 12];
                OFS_CTRL: begin
                    next_r.cfg.mode = vpc_mode_e'(reg_wdata[1:0]);
                    next_r.tt = reg_wdata[CTRL_TT +: 3];
                end
                OFS_BASE:   next_r.cfg.base = reg_wdata[21:0];
                default: begin
                    next_r.dirty = r.dirty;
                end
            endcase
            if ((reg_addr & FIFO_SPAN) == OFS_FIFO && reg_addr[1:0] == 2'h0) begin
                next_r.push = 1'b1;
                next_r.pdata = reg_wdata;
                next_r.tt = TT_FIFO;
            end
        end
        if (reg_rd) begin
            unique case (reg_addr)
                OFS_WSIZE: begin
                    next_r.rdata[LO_LSB +: 12] = r.cfg.width;
                    next_r.rdata[HI_LSB +: 9] = r.cfg.height;
                end
                OFS_OFFS: begin
                    next_r.rdata[LO_LSB +: 12] = r.cfg.hoff;
                    next_r.rdata[HI_LSB +: 9] = r.cfg.voff;
                end
                OFS_BMASK:  next_r.rdata = r.cfg.bmask;
                OFS_LMASK:  next_r.rdata = r.cfg.lmask;
                OFS_STRIDE: next_r.rdata[LO_LSB +: 12] = r.cfg.stride;
                OFS_CTRL: begin
                    next_r.rdata[1:0] = r.cfg.mode;
                    next_r.rdata[CTRL_TT +: 3] = r.tt;
                end
                OFS_BASE:   next_r.rdata[21:0] = r.cfg.base;
                OFS_STAT: begin
                    next_r.rdata[3:0] = fifo_free;
                    next_r.rdata[STAT_TT +: 3] = r.tt;
                    next_r.rdata[STAT_BUSY] = r.dirty | (r.req != r.ack_s2);
                end
                default:    next_r.rdata = REG_RESET;
            endcase
        end
        // Hand a stable snapshot to the link once it has taken the last one
        if (r.dirty && (r.req == r.ack_s2) && !reg_wr) begin
            next_r.shadow = r.cfg;
            next_r.req = ~r.req;
            next_r.dirty = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            r <= '0;
            r.dirty <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Link side
    logic        hs_edge;
    logic        vs_edge;
    logic        video;
    logic        in_data;
    logic        width_ok;
    logic [1:0]  shift;
    logic [6:0]  grp_full;
    logic [12:0] pix;

    always_comb begin
        next_l = l;
        next_l.req_s1 = r.req;
        next_l.req_s2 = l.req_s1;
        next_l.hs = {l.hs[1:0], line_sync};
        next_l.vs = {l.vs[1:0], frame_sync};
        next_l.pd_s1 = pix_data;
        next_l.pd_s2 = l.pd_s1;
        next_l.out.we = 1'b0;
        hs_edge = l.hs[1] & ~l.hs[2];
        vs_edge = l.vs[1] & ~l.vs[2];
        video = is_video(l.cfg.mode);
        shift = (l.cfg.mode == MODE_VIDEO16) ? 2'h1 :
                (l.cfg.mode == MODE_PASS) ? 2'h2 : 2'h0;
        grp_full = l.bcnt >> shift;
        in_data = !video || (l.hcnt >= {1'b0, l.cfg.hoff} + HOFF_BIAS);
        pix = (l.cfg.mode == MODE_VIDEO16) ? {1'b0, l.pcnt[12:1]} : l.pcnt;
        width_ok = !video || (pix < {1'b0, l.cfg.width} + WIDTH_BIAS);
        if (l.req_s2 != l.req_seen) begin
            next_l.cfg = r.shadow;
            next_l.req_seen = l.req_s2;
        end
        if (vs_edge) begin
            next_l.vline = 9'h000;
            next_l.vdec = 5'h00;
            next_l.lines = 10'h000;
            next_l.line_on = 1'b0;
            next_l.first = 1'b1;
            next_l.line_start = l.cfg.base;
            next_l.addr = l.cfg.base;
        end else if (hs_edge) begin
            next_l.hcnt = 13'h0000;
            next_l.bcnt = 7'h00;
            next_l.pcnt = 13'h0000;
            next_l.vline = (l.vline == 9'h1ff) ? l.vline : l.vline + 9'h001;
            next_l.vdec = l.vdec + 5'h01;
            next_l.first = 1'b0;
            if (!l.first) begin
                next_l.line_start = l.line_start + {10'h000, l.cfg.stride};
            end
            next_l.addr = next_l.line_start;
            next_l.line_on = (l.cfg.mode != MODE_IDLE) && l.cfg.lmask[l.vdec];
            if (video) begin
                if (l.vline < l.cfg.voff) begin
                    next_l.line_on = 1'b0;
                end else begin
                    if (l.lines > {1'b0, l.cfg.height}) begin
                        next_l.line_on = 1'b0;
                    end
                    if (l.lines != 10'h3ff) begin
                        next_l.lines = l.lines + 10'h001;
                    end
                end
            end
        end else begin
            next_l.hcnt = sat13(l.hcnt);
            if (!video || l.cfg.hoff == 12'h000 || in_data) begin
                next_l.bcnt = l.bcnt + 7'h01;
            end
            if (l.line_on && in_data && width_ok) begin
                next_l.pcnt = sat13(l.pcnt);
                if (!l.cfg.bmask[grp_full[4:0]]) begin
                    next_l.out.we = 1'b1;
                    next_l.out.addr = l.addr;
                    next_l.out.data = l.pd_s2;
                    next_l.addr = l.addr + 22'h000001;
                end
            end
        end
    end

    always_ff @(posedge port_pixel_clock or negedge resetn) begin
        if (!resetn) begin
            l <= '0;
            l.first <= 1'b1;
        end else begin
            l <= next_l;
        end
    end

    ////////////////////////////////////////////////////////////////////
    assign reg_rdata = r.rdata;
    assign fifo_push = r.push;
    assign fifo_data = r.pdata;
    assign transaction_type = r.tt;
    assign fb_wr = l.out;

endmodule
`default_nettype wire

// File: vpc_digitizer.sv
// Digitizer model: syncs and pixel bytes
`timescale 1ns/1ps
`default_nettype none
module vpc_digitizer (
    input  wire logic      port_pixel_clock, // Link clk
    output var logic       line_sync,        // Line
    output var logic       frame_sync,       // Frame
    output var logic [7:0] pix_data          // Byte
);
    initial begin
        line_sync = 1'b0;
        frame_sync = 1'b0;
        pix_data = 8'h00;
    end
    // Byte changes every clock, also between lines
    always @(posedge port_pixel_clock) pix_data <= pix_data + 8'h01;
    task automatic frame(input int lines);
        @(posedge port_pixel_clock);
        frame_sync <= 1'b1;
        repeat (2) @(posedge port_pixel_clock);
        frame_sync <= 1'b0;
        repeat (6) @(posedge port_pixel_clock);
        for (int l = 0; l < lines; l++) begin
            line_sync <= 1'b1;
            repeat (2) @(posedge port_pixel_clock);
            line_sync <= 1'b0;
            repeat (14) @(posedge port_pixel_clock);
        end
    endtask
endmodule
`default_nettype wire

// File: vpc_pkg.sv
// Constants and types for the video port capture path
// Operation
// - Capture window height field plus one lines
// - Width and height count after the offsets
// - Accept pixels hoff plus two clocks after sync
// - Skip voff line syncs after frame sync
// - Byte mask bit one discards, zero writes
// - Mask bit covers one, two or four bytes
// - Byte mask restarts per line or offset
// - Line mask bit zero discards, one keeps
// - Line mask counts from frame sync always
// - Stride added to line start each sync but the first
// - Writes to eight FIFO words push data
// - Window and offsets apply only in video modes
// - FIFO write sets transaction type code
package vpc_pkg;
    localparam logic [15:0] OFS_WSIZE  = 16'hff24;
    localparam logic [15:0] OFS_OFFS   = 16'hff28;
    localparam logic [15:0] OFS_BMASK  = 16'hff2c;
    localparam logic [15:0] OFS_LMASK  = 16'hff30;
    localparam logic [15:0] OFS_STRIDE = 16'hff34;
    localparam logic [15:0] OFS_FIFO   = 16'hff40;
    localparam logic [15:0] FIFO_SPAN  = 16'hffe0;
    localparam logic [15:0] OFS_CTRL   = 16'hff60;
    localparam logic [15:0] OFS_BASE   = 16'hff64;
    localparam logic [15:0] OFS_STAT   = 16'hff68;
    localparam int          LO_LSB     = 0;
    localparam int          HI_LSB     = 16;
    localparam int          CTRL_TT    = 4;
    localparam int          STAT_TT    = 4;
    localparam int          STAT_BUSY  = 8;
    localparam logic [2:0]  TT_FIFO    = 3'h6;
    localparam logic [12:0] HOFF_BIAS  = 13'h0002;
    localparam logic [12:0] WIDTH_BIAS = 13'h0002;
    localparam logic [31:0] REG_RESET  = 32'h00000000;

    typedef enum logic [1:0] {MODE_IDLE, MODE_VIDEO8, MODE_VIDEO16, MODE_PASS} vpc_mode_e;

    typedef struct packed {
        vpc_mode_e   mode;
        logic [11:0] width;
        logic [8:0]  height;
        logic [11:0] hoff;
        logic [8:0]  voff;
        logic [31:0] bmask;
        logic [31:0] lmask;
        logic [11:0] stride;
        logic [21:0] base;
    } vpc_cfg_s;

    typedef struct packed {
        logic        we;
        logic [21:0] addr;
        logic [7:0]  data;
    } vpc_fbwr_s;
endpackage

// File: vpc_props.sv
// Port assertions of the capture path
`timescale 1ns/1ps
`default_nettype none
module vpc_props
    import vpc_pkg::*;
(
    input wire logic        ref_clk,          // Clock
    input wire logic        resetn,           // Reset
    input wire logic [15:0] reg_addr,         // Addr
    input wire logic [31:0] reg_wdata,        // Wdata
    input wire logic        reg_wr,           // Write
    input wire logic        reg_rd,           // Read
    input wire logic [31:0] reg_rdata,        // Rdata
    input wire logic [3:0]  fifo_free,        // Free
    input wire logic        fifo_push,        // Push
    input wire logic [31:0] fifo_data,        // Word
    input wire logic [2:0]  transaction_type, // Type
    input wire logic        port_pixel_clock, // Link clk
    input wire logic        line_sync,        // Line
    input wire logic        frame_sync,       // Frame
    input wire logic [7:0]  pix_data,         // Byte
    input wire vpc_fbwr_s   fb_wr             // Byte write
);
    sequence s_win_wr;
        reg_wr && reg_addr[15:5] == OFS_FIFO[15:5];
    endsequence
    sequence s_good_wr;
        s_win_wr ##0 reg_addr[1:0] == 2'h0;
    endsequence
    a_push_follows: assert property (@(posedge ref_clk) disable iff (!resetn)
        s_good_wr |=> fifo_push && fifo_data == $past(reg_wdata)) else $error("no push");
    a_push_cause: assert property (@(posedge ref_clk) disable iff (!resetn)
        fifo_push |-> $past(reg_wr)) else $error("stray push");
    a_skew_refused: assert property (@(posedge ref_clk) disable iff (!resetn)
        s_win_wr ##0 reg_addr[1:0] != 2'h0 |=> !fifo_push) else $error("skewed push");
    a_push_type: assert property (@(posedge ref_clk) disable iff (!resetn)
        fifo_push |-> transaction_type == TT_FIFO) else $error("bad type");
    a_type_stays: assert property (@(posedge ref_clk) disable iff (!resetn)
        fifo_push && !reg_wr |=> transaction_type == TT_FIFO) else $error("type lost");
    a_word_holds: assert property (@(posedge ref_clk) disable iff (!resetn)
        !fifo_push |-> $stable(fifo_data)) else $error("word moved");
    a_read_once: assert property (@(posedge ref_clk) disable iff (!resetn)
        !$past(reg_rd) |-> reg_rdata == 32'h0) else $error("rdata stuck");
    a_addr_step: assert property (@(posedge port_pixel_clock) disable iff (!resetn)
        fb_wr.we && $past(fb_wr.we) |-> fb_wr.addr == $past(fb_wr.addr) + 22'h1) else $error("addr gap");
endmodule
`default_nettype wire
